// ===== dpsl_consts.vh
// constants of the debug port security lock
`ifndef DPSL_CONSTS_VH
`define DPSL_CONSTS_VH

`define DPSL_WORD_W 32
`define DPSL_CNT_W 6
`define DPSL_VOTE_MIN 6'd28
`define DPSL_BLK_W 2
`define DPSL_NUM_BLK 4
`define DPSL_LVL_W 2
`define DPSL_PROT_W 8
`define DPSL_PROT_RST 8'h00
`define DPSL_WORD_RST 32'h0000_0000

// protection levels: at or above these a block operation is refused; full-device operations ignore them
`define DPSL_LVL_NONE 2'h0
`define DPSL_LVL_NO_WRITE 2'h1
`define DPSL_LVL_NO_READ 2'h2

// operation codes from the programming front end
`define DPSL_OP_W 3
`define DPSL_OP_FULL_ERASE 3'h0
`define DPSL_OP_FULL_PROG 3'h1
`define DPSL_OP_FULL_VERIFY 3'h2
`define DPSL_OP_BLK_ERASE 3'h3
`define DPSL_OP_BLK_PROG 3'h4
`define DPSL_OP_BLK_VERIFY 3'h5

// general-purpose pins taken by each debug and trace port
`define DPSL_PIN_W 4
`define DPSL_PINS_NONE 4'h0
`define DPSL_PINS_JTAG 4'h4
`define DPSL_PINS_JTAG_RST 4'h5
`define DPSL_PINS_SWD 4'h2
`define DPSL_PINS_SWV 4'h1
`define DPSL_PINS_TRACE 4'h5

`endif

// ===== dpsl_vote.v
// super-majority comparison of the latch cells against the key
`timescale 1ns/1ps
`include "dpsl_consts.vh"
module dpsl_vote #(
  parameter [`DPSL_WORD_W-1:0] KEY = 32'hA5C3_0F96
) (
  input wire [`DPSL_WORD_W-1:0] cells_i,
  output reg match_o
);
  integer i;
  reg [`DPSL_CNT_W-1:0] hits;
  always @* begin
    hits = {`DPSL_CNT_W{1'b0}};
    for (i = 0; i < `DPSL_WORD_W; i = i + 1) begin
      if (cells_i[i] == KEY[i]) begin
        hits = hits + 6'h01;
      end
    end
    // a few failed cells must not drop the lock
    match_o = (hits >= `DPSL_VOTE_MIN);
  end
endmodule

// ===== dpsl_top.v
// device security lock: latch, lock sampling, port and flash gating
`timescale 1ns/1ps
`include "dpsl_consts.vh"
module dpsl_top #(
  // arbitrary value; the real key is set at integration
  parameter [`DPSL_WORD_W-1:0] LOCK_KEY = 32'hA5C3_0F96
) (
  input wire sys_clk_i,
  input wire resetn_i,
  input wire [`DPSL_WORD_W-1:0] nvl_cells_i,
  input wire key_load_i,
  input wire [`DPSL_WORD_W-1:0] key_data_i,
  input wire key_commit_i,
  input wire swd_rd_i,
  input wire dbg_entry_i,
  input wire test_entry_i,
  input wire cfg_jtag_i,
  input wire cfg_jtag_rst_i,
  input wire cfg_swd_i,
  input wire cfg_swv_i,
  input wire cfg_trace_i,
  input wire prot_wr_i,
  input wire [`DPSL_BLK_W-1:0] prot_blk_i,
  input wire [`DPSL_LVL_W-1:0] prot_lvl_i,
  input wire op_req_i,
  input wire [`DPSL_OP_W-1:0] op_code_i,
  input wire [`DPSL_BLK_W-1:0] op_blk_i,
  output reg lock_o,
  output reg nvl_prog_o,
  output reg [`DPSL_WORD_W-1:0] nvl_prog_data_o,
  output reg key_refused_o,
  output reg swd_rd_valid_o,
  output reg [`DPSL_WORD_W-1:0] swd_rd_data_o,
  output reg dbg_mode_o,
  output reg test_mode_o,
  output reg jtag_en_o,
  output reg swd_en_o,
  output reg swv_en_o,
  output reg trace_en_o,
  output reg [`DPSL_PIN_W-1:0] dbg_pins_o,
  output reg [`DPSL_PROT_W-1:0] prot_o,
  output reg op_done_o,
  output reg op_ok_o
);

  reg lock_ff;
  reg [`DPSL_WORD_W-1:0] vol_ff;
  reg [`DPSL_PROT_W-1:0] prot_ff;
  reg [`DPSL_PROT_W-1:0] nxt_prot;
  reg nxt_op_ok;
  reg [`DPSL_PIN_W-1:0] nxt_pins;
  reg [`DPSL_LVL_W-1:0] blk_lvl;
  reg [`DPSL_LVL_W-1:0] cur_lvl;
  wire vote_match;
  wire prot_none;
  wire key_ok;
  integer b;

  dpsl_vote #(
    .KEY(LOCK_KEY)
  ) u_vote (
    .cells_i(nvl_cells_i),
    .match_o(vote_match)
  );

  assign prot_none = (prot_ff == `DPSL_PROT_RST);
  // key changes need an unlocked part with no protection set
  assign key_ok = !lock_ff && prot_none;

  // the lock samples the cells only while reset is held, so a key
  // committed now does not change the lock until the part is reset
  always @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      lock_ff <= vote_match;
    end
  end

  always @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      vol_ff <= `DPSL_WORD_RST;
      nvl_prog_o <= 1'b0;
      nvl_prog_data_o <= `DPSL_WORD_RST;
      key_refused_o <= 1'b0;
    end else begin
      nvl_prog_o <= 1'b0;
      key_refused_o <= 1'b0;
      if (key_load_i) begin
        if (key_ok) begin
          vol_ff <= key_data_i;
        end else begin
          key_refused_o <= 1'b1;
        end
      end else if (key_commit_i) begin
        if (key_ok) begin
          nvl_prog_o <= 1'b1;
          nvl_prog_data_o <= vol_ff;
        end else begin
          key_refused_o <= 1'b1;
        end
      end
    end
  end

  // readback stays open when locked so protected parts can be told
  always @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      swd_rd_valid_o <= 1'b0;
      swd_rd_data_o <= `DPSL_WORD_RST;
    end else begin
      swd_rd_valid_o <= swd_rd_i;
      if (swd_rd_i) begin
        swd_rd_data_o <= nvl_cells_i;
      end
    end
  end

  // pin reservation per enabled port combination
  always @* begin
    nxt_pins = `DPSL_PINS_NONE;
    if (cfg_jtag_i) begin
      if (cfg_jtag_rst_i) begin
        nxt_pins = nxt_pins + `DPSL_PINS_JTAG_RST;
      end else begin
        nxt_pins = nxt_pins + `DPSL_PINS_JTAG;
      end
    end else if (cfg_swd_i) begin
      nxt_pins = nxt_pins + `DPSL_PINS_SWD;
      if (cfg_swv_i && !cfg_trace_i) begin
        nxt_pins = nxt_pins + `DPSL_PINS_SWV;
      end
    end else if (cfg_swv_i && !cfg_trace_i) begin
      nxt_pins = nxt_pins + `DPSL_PINS_SWV;
    end
    if (cfg_trace_i) begin
      nxt_pins = nxt_pins + `DPSL_PINS_TRACE;
    end
    if (lock_ff) begin
      nxt_pins = `DPSL_PINS_NONE;
    end
  end

  // enables follow the reset-time lock, never the live vote
  always @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      jtag_en_o <= 1'b0;
      swd_en_o <= 1'b0;
      swv_en_o <= 1'b0;
      trace_en_o <= 1'b0;
      dbg_pins_o <= `DPSL_PINS_NONE;
      dbg_mode_o <= 1'b0;
      test_mode_o <= 1'b0;
      lock_o <= 1'b0;
    end else begin
      lock_o <= lock_ff;
      jtag_en_o <= cfg_jtag_i && !lock_ff;
      swd_en_o <= cfg_swd_i && !cfg_jtag_i && !lock_ff;
      swv_en_o <= cfg_swv_i && !cfg_trace_i && !lock_ff;
      trace_en_o <= cfg_trace_i && !lock_ff;
      dbg_pins_o <= nxt_pins;
      if (lock_ff) begin
        dbg_mode_o <= 1'b0;
        test_mode_o <= 1'b0;
      end else begin
        if (dbg_entry_i) begin
          dbg_mode_o <= 1'b1;
        end
        if (test_entry_i) begin
          test_mode_o <= 1'b1;
        end
      end
    end
  end

  // flash protection and programming operation permissions
  always @* begin
    nxt_prot = prot_ff;
    nxt_op_ok = 1'b0;
    blk_lvl = `DPSL_LVL_NONE;
    cur_lvl = `DPSL_LVL_NONE;
    for (b = 0; b < `DPSL_NUM_BLK; b = b + 1) begin
      if (op_blk_i == b[`DPSL_BLK_W-1:0]) begin
        blk_lvl = prot_ff[b*`DPSL_LVL_W +: `DPSL_LVL_W];
      end
      if (prot_blk_i == b[`DPSL_BLK_W-1:0]) begin
        cur_lvl = prot_ff[b*`DPSL_LVL_W +: `DPSL_LVL_W];
      end
    end
    if (op_req_i && !lock_ff) begin
      if (op_code_i == `DPSL_OP_FULL_ERASE) begin
        nxt_prot = `DPSL_PROT_RST;
        nxt_op_ok = 1'b1;
      end else if (op_code_i == `DPSL_OP_FULL_PROG) begin
        nxt_op_ok = 1'b1;
      end else if (op_code_i == `DPSL_OP_FULL_VERIFY) begin
        nxt_op_ok = 1'b1;
      end else if (op_code_i == `DPSL_OP_BLK_ERASE) begin
        nxt_op_ok = (blk_lvl < `DPSL_LVL_NO_WRITE);
      end else if (op_code_i == `DPSL_OP_BLK_PROG) begin
        nxt_op_ok = (blk_lvl < `DPSL_LVL_NO_WRITE);
      end else if (op_code_i == `DPSL_OP_BLK_VERIFY) begin
        nxt_op_ok = (blk_lvl < `DPSL_LVL_NO_READ);
      end
    end else if (prot_wr_i && !lock_ff && prot_lvl_i > cur_lvl) begin
      // a lower level is ignored, so protection only rises until a full erase or a reset clears it
      nxt_prot[prot_blk_i*`DPSL_LVL_W +: `DPSL_LVL_W] = prot_lvl_i;
    end
  end

  always @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      prot_ff <= `DPSL_PROT_RST;
      prot_o <= `DPSL_PROT_RST;
      op_done_o <= 1'b0;
      op_ok_o <= 1'b0;
    end else begin
      prot_ff <= nxt_prot;
      prot_o <= nxt_prot;
      op_done_o <= op_req_i;
      op_ok_o <= nxt_op_ok;
    end
  end

endmodule

// ===== dpsl_top_asserts.sv
// assertion checker for the debug port security lock
`timescale 1ns/1ps
`include "dpsl_consts.vh"
module dpsl_top_asserts (
  input wire sys_clk_i,
  input wire resetn_i,
  input wire [`DPSL_WORD_W-1:0] nvl_cells_i,
  input wire key_load_i,
  input wire swd_rd_i,
  input wire op_req_i,
  input wire lock_o,
  input wire nvl_prog_o,
  input wire key_refused_o,
  input wire swd_rd_valid_o,
  input wire [`DPSL_WORD_W-1:0] swd_rd_data_o,
  input wire dbg_mode_o,
  input wire jtag_en_o,
  input wire swd_en_o,
  input wire [`DPSL_PIN_W-1:0] dbg_pins_o,
  input wire [`DPSL_PROT_W-1:0] prot_o,
  input wire op_done_o,
  input wire op_ok_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  a_locked_no_debug: assert property (
    lock_o |-> !dbg_mode_o) else $error("debug mode while locked");
  a_locked_ports_off: assert property (
    lock_o |-> !jtag_en_o && !swd_en_o && dbg_pins_o == 4'h0)
    else $error("port open while locked");
  a_locked_no_commit: assert property (
    lock_o |-> !nvl_prog_o) else $error("latch commit while locked");
  a_locked_key_refused: assert property (
    lock_o && key_load_i |=> key_refused_o) else $error("key not refused");
  a_prot_key_refused: assert property (
    key_load_i && prot_o != 8'h00 |=> key_refused_o)
    else $error("key taken under protection");
  // lock may only move across a reset
  a_lock_held: assert property (
    $past(resetn_i) && $past(resetn_i, 2) |-> $stable(lock_o))
    else $error("lock changed between resets");
  a_swd_readback: assert property (
    swd_rd_i |=> swd_rd_valid_o && swd_rd_data_o == $past(nvl_cells_i))
    else $error("latch readback wrong");
  a_locked_op_refused: assert property (
    lock_o && op_req_i |=> op_done_o && !op_ok_o)
    else $error("operation run while locked");
  a_op_answered: assert property (
    $past(resetn_i) |-> op_done_o == $past(op_req_i))
    else $error("operation answer missing");
  a_prot_no_drop: assert property (
    $past(resetn_i) && !$past(op_req_i) |->
    prot_o[1:0] >= $past(prot_o[1:0]) && prot_o[3:2] >= $past(prot_o[3:2])
    && prot_o[5:4] >= $past(prot_o[5:4])
    && prot_o[7:6] >= $past(prot_o[7:6]))
    else $error("protection level dropped");
endmodule
bind dpsl_top dpsl_top_asserts u_dpsl_top_asserts (.*);

// ===== dpsl_host_model.sv
// external debug and programming host model
`timescale 1ns/1ps
module dpsl_host_model (
  input wire sys_clk_i,
  output reg [5:0] strb_o,
  output reg [31:0] data_o
);
  // strobes: load, commit, read, mode entry, prot write, operation
  initial begin
    strb_o = 6'h00;
    data_o = 32'h0000_0000;
  end
  task req(input integer k, input [31:0] d, input integer idle);
    begin
      repeat (idle + 1) @(posedge sys_clk_i);
      strb_o <= 6'h01 << k;
      data_o <= d;
      @(posedge sys_clk_i);
      strb_o <= 6'h00;
      // released lines show the inverse so stale data never matches
      data_o <= ~d;
    end
  endtask
endmodule

// ===== dpsl_top_tb.sv
// self-checking bench of the debug port security lock
`timescale 1ns/1ps
`include "dpsl_consts.vh"
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin num_errors++; \
  $display("unexpected at %0t: %h %h", $time, a, e); end end
module dpsl_top_tb;
  localparam [31:0] KEY = 32'h1234_5678; // arbitrary key value
  reg sys_clk_i = 1'b0;
  reg resetn_i = 1'b0;
  reg [31:0] nvl_cells_i = 32'h0;
  reg [4:0] cfg = 5'h00;
  reg [2:0] en_exp;
  integer num_errors = 0, tests_run = 0, cyc = 0, i;
  wire [5:0] s;
  wire [31:0] hd, nvl_prog_data_o, swd_rd_data_o;
  wire lock_o, nvl_prog_o, key_refused_o, swd_rd_valid_o, dbg_mode_o;
  wire test_mode_o, jtag_en_o, swd_en_o, swv_en_o, trace_en_o;
  wire op_done_o, op_ok_o;
  wire [3:0] dbg_pins_o;
  wire [7:0] prot_o;
  always #20 sys_clk_i = ~sys_clk_i;
  dpsl_host_model u_dpsl_host_model (.sys_clk_i(sys_clk_i), .strb_o(s),
    .data_o(hd));
  dpsl_top #(.LOCK_KEY(KEY)) u_dpsl_top (.key_load_i(s[0]),
    .key_data_i(hd), .key_commit_i(s[1]), .swd_rd_i(s[2]),
    .dbg_entry_i(s[3]), .test_entry_i(s[3]), .cfg_jtag_i(cfg[4]),
    .cfg_jtag_rst_i(cfg[3]), .cfg_swd_i(cfg[2]), .cfg_swv_i(cfg[1]),
    .cfg_trace_i(cfg[0]), .prot_wr_i(s[4]), .prot_blk_i(hd[9:8]),
    .prot_lvl_i(hd[13:12]), .op_req_i(s[5]), .op_code_i(hd[2:0]),
    .op_blk_i(hd[5:4]), .*);
  // the cells keep whatever the commit pulse programs
  always @(posedge sys_clk_i) if (nvl_prog_o) nvl_cells_i <= nvl_prog_data_o;
  task finish_test;
    begin
      $display("checks %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      num_errors++;
      finish_test;
    end
  end
  task rq(input integer k, input [31:0] d);
    begin
      u_dpsl_host_model.req(k, d, 0);
      #1;
    end
  endtask
  task do_reset(input [31:0] c);
    begin
      @(posedge sys_clk_i);
      resetn_i <= 1'b0;
      nvl_cells_i <= c;
      repeat (3) @(posedge sys_clk_i);
      resetn_i <= 1'b1;
      repeat (2) @(posedge sys_clk_i);
      #1;
    end
  endtask
  function [3:0] pins_of(input [4:0] c);
    begin
      pins_of = c[4] ? (c[3] ? 4'h5 : 4'h4) : 4'h0;
      if (c[2] && !c[4]) pins_of = pins_of + 4'h2;
      // the single swv pin is one of the jtag pins, so it adds none there
      if (c[1] && !c[0] && !c[4]) pins_of = pins_of + 4'h1;
      if (c[0]) pins_of = pins_of + 4'h5;
    end
  endfunction
  task t_ports;
    for (i = 0; i < 32; i++) begin
      @(posedge sys_clk_i) cfg <= i[4:0];
      @(posedge sys_clk_i) #1;
      `CHK(dbg_pins_o, pins_of(cfg))
      `CHK(trace_en_o, cfg[0])
      en_exp = {cfg[4], cfg[2] & ~cfg[4], cfg[1] & ~cfg[0]};
      `CHK({jtag_en_o, swd_en_o, swv_en_o}, en_exp)
    end
    $display("port table done");
  endtask
  task t_prot;
    for (i = 0; i < 6; i++) begin
      rq(5, i);
      `CHK(op_ok_o, 1'b1)
    end
    rq(4, 32'h1100);
    `CHK(prot_o, 8'h04)
    rq(5, 32'h14);
    `CHK(op_ok_o, 1'b0)
    rq(5, 32'h15);
    `CHK(op_ok_o, 1'b1)
    rq(4, 32'h2100);
    rq(5, 32'h15);
    `CHK(op_ok_o, 1'b0)
    rq(4, 32'h1100);
    `CHK(prot_o, 8'h08)
    rq(0, KEY);
    `CHK(key_refused_o, 1'b1)
    rq(5, 32'h0);
    `CHK(prot_o, 8'h00)
    $display("protection done");
  endtask
  task t_key;
    rq(0, KEY);
    `CHK(key_refused_o, 1'b0)
    u_dpsl_host_model.req(1, 32'h0, 2);
    #1;
    `CHK(nvl_prog_data_o, KEY)
    @(posedge sys_clk_i) #1;
    `CHK({lock_o, jtag_en_o}, 2'h1)
    rq(2, 32'h0);
    `CHK(swd_rd_data_o, KEY)
    $display("key write done");
  endtask
  task t_lock(input [31:0] c, input exp);
    do_reset(c);
    `CHK(lock_o, exp)
    rq(2, 32'h0);
    `CHK(swd_rd_data_o, c)
    rq(3, 32'h0);
    `CHK({dbg_mode_o, test_mode_o}, {2{!exp}})
    rq(1, 32'h0);
    `CHK({nvl_prog_o, key_refused_o}, {!exp, exp})
    @(posedge sys_clk_i) nvl_cells_i <= 32'h0;
    rq(5, 32'h0);
    `CHK({op_done_o, op_ok_o, lock_o}, {1'b1, !exp, exp})
    $display("lock check done");
  endtask
  initial begin
    do_reset(32'h0);
    t_ports;
    t_prot;
    t_key;
    t_lock(KEY ^ 32'h0000_000F, 1'b1);
    t_lock(KEY ^ 32'h0000_001F, 1'b0);
    finish_test;
  end
endmodule
